//--- rtl/ermd_consts.vh
// Purpose: Shared constants of the receive MAC datapath.
// Assumes: Included by bare name from every design file.
// Notes:   Register indices are word indices; byte address is index * 4.
`ifndef ERMD_CONSTS_VH
`define ERMD_CONSTS_VH

// ----------------------------------------------------------------------
// Register word indices
// ----------------------------------------------------------------------
`define ERMD_IDX_FILTER   10'h103
`define ERMD_IDX_CRC      10'h104
`define ERMD_IDX_PAD      10'h105
`define ERMD_IDX_MAXLEN   10'h106
`define ERMD_IDX_STATS    10'h107
`define ERMD_IDX_OCTETS   10'h108
`define ERMD_IDX_PREAMBLE 10'h125
`define ERMD_IDX_DMCTRL   10'h140
`define ERMD_IDX_DALO     10'h141
`define ERMD_IDX_DAHI     10'h142

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ERMD_FLT_CUT      0
`define ERMD_FLT_PAUSE    1
`define ERMD_FLT_CTRL     2
`define ERMD_FLT_RUNT     3
`define ERMD_FLT_OVER     4
`define ERMD_FLT_FCS      5
`define ERMD_FLT_RATE100  8
`define ERMD_CRC_STRIP    1
`define ERMD_PAD_EN       0
`define ERMD_PP_EN        0
`define ERMD_DMC_EN_LO    0
`define ERMD_DMC_EN_HI    30

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ERMD_RST_FILTER   32'h00000000
`define ERMD_RST_CRC      32'h00000002
`define ERMD_RST_PAD      32'h00000000
`define ERMD_RST_MAXLEN   32'h000005ee
`define ERMD_RST_PP       32'h00000000
`define ERMD_RST_ZERO     32'h00000000

// ----------------------------------------------------------------------
// Line codes, frame figures, CRC
// ----------------------------------------------------------------------
`define ERMD_CH_START     8'hfb
`define ERMD_CH_TERM      8'hfd
`define ERMD_CH_PRE       8'h55
`define ERMD_CH_SFD       8'hd5
`define ERMD_PRE_COUNT    3'h6
`define ERMD_MIN_FRAME    14'h0040
`define ERMD_SLACK100     14'h002c
`define ERMD_SLACK40      14'h0014
`define ERMD_PAD_MIN      16'h002e
`define ERMD_HDR_LAST     14'h000d
`define ERMD_CT_LAG       14'h0005
`define ERMD_CRC_LEN      14'h0004
`define ERMD_TYPE_CTRL    16'h8808
`define ERMD_OPC_PAUSE    16'h0001
`define ERMD_CRC_INIT     32'hffffffff
`define ERMD_CRC_POLY     32'hedb88320
`define ERMD_CRC_RESIDUE  32'hdebb20e3
`define ERMD_AW           14
`define ERMD_DW_DESC      29

`endif

//--- rtl/ermd_crc32.v
// Purpose: Byte-wide CRC-32 accumulator, reflected form.
// Assumes: One byte per enabled clock, bit 0 of each byte first.
// Notes:   Residue compare after the FCS bytes gives the check.
`timescale 1ns/1ps
`include "ermd_consts.vh"

module ermd_crc32 (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        clear,
  input  wire        enable,
  input  wire [7:0]  data,
  output reg  [31:0] crc
);

  reg     [31:0] next_crc;
  integer        i;

  // Bit 0 first: highest term lands in the first byte's low bit
  always @* begin
    next_crc = crc;
    for (i = 0; i < 8; i = i + 1) begin
      if (next_crc[0] ^ data[i])
        next_crc = (next_crc >> 1) ^ `ERMD_CRC_POLY;
      else
        next_crc = next_crc >> 1;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      crc <= `ERMD_CRC_INIT;
    else if (clear)
      crc <= `ERMD_CRC_INIT;
    else if (enable)
      crc <= next_crc;
  end

endmodule

//--- rtl/ermd_desc_fifo.v
// Purpose: Small queue of completed-frame descriptors.
// Assumes: Push and pop never both hit an empty queue.
// Notes:   Four entries; writer drops a frame when it is full.
`timescale 1ns/1ps
`include "ermd_consts.vh"

module ermd_desc_fifo (
  input  wire                      mclk,
  input  wire                      rst_n,
  input  wire                      push,
  input  wire                      pop,
  input  wire [`ERMD_DW_DESC-1:0]  din,
  output wire [`ERMD_DW_DESC-1:0]  dout,
  output wire                      empty,
  output wire                      full
);

  reg [`ERMD_DW_DESC-1:0] slots [0:3];
  reg [1:0]               head;
  reg [1:0]               tail;
  reg [2:0]               count;

  assign dout  = slots[head];
  assign empty = (count == 3'h0);
  assign full  = (count == 3'h4);

  always @(posedge mclk)
    if (push && !full)
      slots[tail] <= din;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      head  <= 2'h0;
      tail  <= 2'h0;
      count <= 3'h0;
    end else begin
      if (push && !full)
        tail <= tail + 2'h1;
      if (pop && !empty)
        head <= head + 2'h1;
      count <= count + {2'h0, push && !full} - {2'h0, pop && !empty};
    end
  end

endmodule

//--- rtl/ermd_rx_mac.v
// Purpose: Receive MAC datapath: preamble check, filter, CRC, client stream.
// Assumes: One line byte per clock with a control flag, no back-pressure.
// Notes:   Frame buffer is a 16 KiB ring; mode changes apply at once, preamble mode per frame start.
`timescale 1ns/1ps
`include "ermd_consts.vh"

module ermd_rx_mac (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [11:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        lineValid,
  input  wire        lineCtrl,
  input  wire [7:0]  lineData,
  output reg  [7:0]  outData,
  output reg         outValid,
  output reg         outSop,
  output reg         outEop,
  output reg         outFcsValid,
  output reg         outFcsError
);

  localparam W_IDLE = 2'h0;
  localparam W_PRE  = 2'h1;
  localparam W_DATA = 2'h2;
  localparam W_SKIP = 2'h3;

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg  [31:0] filterCtrl;
  reg  [31:0] crcCfg;
  reg  [31:0] padCfg;
  reg  [31:0] maxLen;
  reg  [31:0] ppCfg;
  reg  [31:0] dmCtrl;
  reg  [31:0] daLo;
  reg  [15:0] daHi;
  reg  [15:0] acceptCount;
  reg  [15:0] dropCount;
  reg  [31:0] octetCount;
  reg  [31:0] rdMux;

  wire [9:0]  regIdx = wb_adr_i[11:2];
  wire        wbReq  = wb_cyc_i & wb_stb_i;
  wire        wbWr   = wbReq & wb_we_i & wb_ack_o;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer      b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (sel[b])
          merge[8*b +: 8] = nw[8*b +: 8];
    end
  endfunction
  wire [31:0] daHiNew = merge({16'h0000, daHi}, wb_dat_i, wb_sel_i);

  always @* begin
    case (regIdx)
      `ERMD_IDX_FILTER:   rdMux = filterCtrl;
      `ERMD_IDX_CRC:      rdMux = crcCfg;
      `ERMD_IDX_PAD:      rdMux = padCfg;
      `ERMD_IDX_MAXLEN:   rdMux = maxLen;
      `ERMD_IDX_STATS:    rdMux = {dropCount, acceptCount};
      `ERMD_IDX_OCTETS:   rdMux = octetCount;
      `ERMD_IDX_PREAMBLE: rdMux = ppCfg;
      `ERMD_IDX_DMCTRL:   rdMux = dmCtrl;
      `ERMD_IDX_DALO:     rdMux = daLo;
      `ERMD_IDX_DAHI:     rdMux = {16'h0000, daHi};
      default:            rdMux = 32'h00000000;
    endcase
  end

  // Write lands on the edge where the master sees ack
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h00000000;
      filterCtrl <= `ERMD_RST_FILTER;
      crcCfg     <= `ERMD_RST_CRC;
      padCfg     <= `ERMD_RST_PAD;
      maxLen     <= `ERMD_RST_MAXLEN;
      ppCfg      <= `ERMD_RST_PP;
      dmCtrl     <= `ERMD_RST_ZERO;
      daLo       <= `ERMD_RST_ZERO;
      daHi       <= 16'h0000;
    end else begin
      wb_ack_o <= wbReq & ~wb_ack_o;
      if (wbReq && !wb_ack_o)
        wb_dat_o <= rdMux;
      if (wbWr) begin
        case (regIdx)
          `ERMD_IDX_FILTER:   filterCtrl <= merge(filterCtrl, wb_dat_i,
                                                  wb_sel_i);
          `ERMD_IDX_CRC:      crcCfg <= merge(crcCfg, wb_dat_i, wb_sel_i);
          `ERMD_IDX_PAD:      padCfg <= merge(padCfg, wb_dat_i,
                                              wb_sel_i);
          `ERMD_IDX_MAXLEN:   maxLen <= merge(maxLen, wb_dat_i, wb_sel_i);
          `ERMD_IDX_PREAMBLE: ppCfg <= merge(ppCfg, wb_dat_i, wb_sel_i);
          `ERMD_IDX_DMCTRL:   dmCtrl <= merge(dmCtrl, wb_dat_i, wb_sel_i);
          `ERMD_IDX_DALO:     daLo <= merge(daLo, wb_dat_i, wb_sel_i);
          `ERMD_IDX_DAHI:     daHi <= daHiNew[15:0];
          default:            daHi <= daHi;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Line parser and frame writer
  // --------------------------------------------------------------------
  reg  [7:0]            mem [0:(1<<`ERMD_AW)-1];
  reg  [1:0]            wrState;
  reg  [2:0]            preCnt;
  reg  [`ERMD_AW-1:0]   wp;
  reg  [`ERMD_AW-1:0]   rp;
  reg  [`ERMD_AW-1:0]   frameStart;
  reg  [13:0]           frameLen;
  reg                   ppLatch;
  reg                   daMiss;
  reg                   ovf;
  reg  [15:0]           typeField;
  reg  [15:0]           opcode;
  reg                   memWant;
  wire [31:0]           crc;
  wire                  fifoEmpty;
  wire                  fifoFull;
  wire [`ERMD_DW_DESC-1:0] desc;

  wire lineDat = lineValid & ~lineCtrl;
  wire lineCtl = lineValid & lineCtrl;
  // Start is only looked for on the single byte lane
  wire isStart = lineCtl && (lineData == `ERMD_CH_START);
  wire room    = (wp + 14'h0001) != rp;
  wire memWe   = memWant & room;
  wire cutThru = filterCtrl[`ERMD_FLT_CUT];
  wire endNow  = (wrState == W_DATA) && lineCtl;

  // Any control byte other than terminate inside a frame is an error
  wire crcBad  = (crc != `ERMD_CRC_RESIDUE) ||
                 (lineData != `ERMD_CH_TERM);

  wire [13:0] slack = filterCtrl[`ERMD_FLT_RATE100] ?
                      `ERMD_SLACK100 : `ERMD_SLACK40;
  wire runt     = frameLen < `ERMD_MIN_FRAME;
  wire oversize = frameLen > (maxLen[13:0] + slack);
  wire isCtl    = typeField == `ERMD_TYPE_CTRL;
  wire isPause  = isCtl && (opcode == `ERMD_OPC_PAUSE);
  wire addrEn   = dmCtrl[`ERMD_DMC_EN_LO] & dmCtrl[`ERMD_DMC_EN_HI];

  // Only enabled criteria decide, valid or not
  wire sfDrop = (addrEn & daMiss) |
                (filterCtrl[`ERMD_FLT_PAUSE] & isPause) |
                (filterCtrl[`ERMD_FLT_CTRL] & isCtl & ~isPause) |
                (filterCtrl[`ERMD_FLT_OVER] & oversize) |
                (filterCtrl[`ERMD_FLT_FCS] & crcBad);
  // Cut-through keeps only the runt test: no address check there
  wire dropNow = (filterCtrl[`ERMD_FLT_RUNT] & runt) |
                 (~cutThru & sfDrop) | ovf | fifoFull;

  wire [47:0] destAddr = {daHi, daLo};
  wire [47:0] daShift  = destAddr >> {(3'h5 - frameLen[2:0]), 3'b000};

  wire [`ERMD_AW-1:0] dataStart = frameStart + {10'h000, ppLatch, 3'b000};
  wire padHit = padCfg[`ERMD_PAD_EN] &&
                (typeField < `ERMD_PAD_MIN);
  wire [`ERMD_AW-1:0] lastAddr =
    padHit ? dataStart + `ERMD_HDR_LAST + typeField[13:0] :
    crcCfg[`ERMD_CRC_STRIP] ? wp - `ERMD_CRC_LEN - 14'h0001 :
    wp - 14'h0001;
  wire descPush = endNow & ~dropNow;

  always @* begin
    case (wrState)
      W_IDLE:  memWant = isStart & ppCfg[`ERMD_PP_EN];
      W_PRE:   memWant = lineDat & ppLatch;
      W_DATA:  memWant = lineDat;
      default: memWant = 1'b0;
    endcase
  end

  always @(posedge mclk)
    if (memWe)
      mem[wp] <= lineData;

  ermd_crc32 crcUnit (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .clear  ((wrState == W_IDLE) && isStart),
    .enable ((wrState == W_DATA) && lineDat),
    .data   (lineData),
    .crc    (crc)
  );

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrState     <= W_IDLE;
      preCnt      <= 3'h0;
      wp          <= 14'h0000;
      frameStart  <= 14'h0000;
      frameLen    <= 14'h0000;
      ppLatch     <= 1'b0;
      daMiss      <= 1'b0;
      ovf         <= 1'b0;
      typeField   <= 16'hffff;
      opcode      <= 16'h0000;
      acceptCount <= 16'h0000;
      dropCount   <= 16'h0000;
      octetCount  <= 32'h00000000;
    end else begin
      if (memWe)
        wp <= wp + 14'h0001;
      case (wrState)
        W_IDLE: begin
          if (isStart) begin
            wrState   <= W_PRE;
            preCnt    <= 3'h0;
            frameLen  <= 14'h0000;
            ppLatch   <= ppCfg[`ERMD_PP_EN];
            daMiss    <= 1'b0;
            ovf       <= 1'b0;
            typeField <= 16'hffff;
            opcode    <= 16'h0000;
          end
        end
        W_PRE: begin
          if (lineCtl) begin
            wp      <= frameStart;
            wrState <= W_IDLE;
          end else if (lineDat) begin
            if (preCnt != `ERMD_PRE_COUNT) begin
              if (lineData == `ERMD_CH_PRE)
                preCnt <= preCnt + 3'h1;
              else begin
                wp      <= frameStart;
                wrState <= W_SKIP;
              end
            end else if (lineData == `ERMD_CH_SFD) begin
              wrState <= W_DATA;
            end else begin
              wp      <= frameStart;
              wrState <= W_SKIP;
            end
          end
        end
        W_DATA: begin
          if (endNow) begin
            wrState <= W_IDLE;
            if (dropNow) begin
              wp        <= frameStart;
              dropCount <= dropCount + 16'h0001;
            end else begin
              frameStart  <= wp;
              acceptCount <= acceptCount + 16'h0001;
              // Counted on the wire length, padding included
              octetCount  <= octetCount + {18'h00000, frameLen};
            end
          end else if (lineDat) begin
            if (frameLen != 14'h3fff)
              frameLen <= frameLen + 14'h0001;
            if (frameLen < 14'h0006 && daShift[7:0] != lineData)
              daMiss <= 1'b1;
            if (frameLen == 14'h000c)
              typeField[15:8] <= lineData;
            if (frameLen == 14'h000d)
              typeField[7:0] <= lineData;
            if (frameLen == 14'h000e)
              opcode[15:8] <= lineData;
            if (frameLen == 14'h000f)
              opcode[7:0] <= lineData;
          end
        end
        W_SKIP: begin
          if (lineCtl)
            wrState <= W_IDLE;
        end
        default: wrState <= W_IDLE;
      endcase
      if (memWant && !room)
        ovf <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Client reader
  // --------------------------------------------------------------------
  reg midFrame;
  wire [`ERMD_AW-1:0] descNext = desc[`ERMD_AW-1:0];
  wire [`ERMD_AW-1:0] descLast = desc[2*`ERMD_AW-1:`ERMD_AW];
  wire                descBad  = desc[`ERMD_DW_DESC-1];
  wire [`ERMD_AW-1:0] ahead    = wp - rp;

  // Streaming waits past the runt limit so a runt is never half sent;
  // lag and pad test keep the reader behind where the end can land.
  wire ctOk = cutThru && (wrState == W_DATA) && !runt && !padHit &&
              (frameLen != `ERMD_MIN_FRAME) &&
              (ahead > `ERMD_CT_LAG);
  wire rdGo    = fifoEmpty ? ctOk : 1'b1;
  wire atEnd   = !fifoEmpty && (rp == descLast);
  wire descPop = rdGo && atEnd;

  ermd_desc_fifo descQ (
    .mclk  (mclk),
    .rst_n (rst_n),
    .push  (descPush),
    .pop   (descPop),
    .din   ({crcBad, lastAddr, wp}),
    .dout  (desc),
    .empty (fifoEmpty),
    .full  (fifoFull)
  );

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rp          <= 14'h0000;
      midFrame    <= 1'b0;
      outData     <= 8'h00;
      outValid    <= 1'b0;
      outSop      <= 1'b0;
      outEop      <= 1'b0;
      outFcsValid <= 1'b0;
      outFcsError <= 1'b0;
    end else begin
      outValid    <= rdGo;
      outSop      <= rdGo & ~midFrame;
      outEop      <= rdGo & atEnd;
      outFcsValid <= rdGo & atEnd;
      outFcsError <= rdGo & atEnd & descBad;
      if (rdGo) begin
        outData  <= mem[rp];
        midFrame <= ~atEnd;
        // Bytes after the end marker (stripped CRC, pad) are skipped
        rp       <= atEnd ? descNext : rp + 14'h0001;
      end
    end
  end

endmodule

//--- test/ermd_line_model.sv
// Purpose: Line-side byte source sending framed packets.
// Assumes: One byte per clock, driven just after the rising edge.
// Notes:   Preamble length and SFD are arguments to build bad leads.
`timescale 1ns/1ps

module ermd_line_model (
  input  wire       mclk,
  output reg        lineValid,
  output reg        lineCtrl,
  output reg  [7:0] lineData
);
  logic [7:0] frm [0:2047];

  initial begin
    lineValid = 1'b0;
    lineCtrl  = 1'b1;
    lineData  = 8'h07;
  end

  function automatic logic [31:0] crcOf(input int n);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < n; i++) begin
      c = c ^ {24'h0, frm[i]};
      for (int b = 0; b < 8; b++)
        c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    end
    return ~c;
  endfunction

  task automatic putByte(input logic v, input logic c, input logic [7:0] d);
    @(posedge mclk);
    lineValid <= v;
    lineCtrl  <= c;
    lineData  <= d;
  endtask

  task automatic send(input int len, input logic [31:0] tyop, input bit bad,
                      input int npre, input logic [7:0] sfd, input int gap);
    logic [31:0] crc;
    for (int i = 0; i < len - 4; i++)
      frm[i] = (i >= 12 && i < 16) ? tyop[8*(15-i)+:8] : i[7:0] ^ 8'h5a;
    crc = crcOf(len - 4);
    // Low CRC byte first carries the top term in its bit 0
    for (int i = 0; i < 4; i++)
      frm[len-4+i] = crc[8*i+:8] ^ {7'h0, bad && i == 0};
    putByte(1'b1, 1'b1, 8'hfb);
    repeat (npre) putByte(1'b1, 1'b0, 8'h55);
    putByte(1'b1, 1'b0, sfd);
    for (int i = 0; i < len; i++) putByte(1'b1, 1'b0, frm[i]);
    putByte(1'b1, 1'b1, 8'hfd);
    putByte(1'b1, 1'b1, 8'h07);
    // Idle gap with no valid bytes, gaps must not look like data
    repeat (gap - 1) putByte(1'b0, 1'b1, 8'h07);
  endtask
endmodule

//--- test/ermd_rx_mac_asserts.sv
// Purpose: Port-level timing checks for the receive MAC.
// Assumes: Sees only the top-level ports; one clock domain.
// Notes:   Frame contents are judged by the bench, not here.
`timescale 1ns/1ps

module ermd_rx_mac_asserts (
  input wire        mclk,
  input wire        rst_n,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        lineValid,
  input wire        lineCtrl,
  input wire [7:0]  lineData,
  input wire [7:0]  outData,
  input wire        outValid,
  input wire        outSop,
  input wire        outEop,
  input wire        outFcsValid,
  input wire        outFcsError
);
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // Bus and stream sequences
  // ----------------------------------------
  sequence sReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence sAckPulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence sFrameEnd;
    outValid && outEop;
  endsequence

  a_ack_after_req: assert property (sReq |=> sAckPulse)
    else $error("ack not a single pulse one cycle after request");
  a_ack_needs_req: assert property
    ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_rdata_holds: assert property ($changed(wb_dat_o) |-> wb_ack_o)
    else $error("read data changed outside an ack");
  a_sop_valid: assert property (outSop |-> outValid)
    else $error("start marker without a valid beat");
  a_eop_flags: assert property (outEop |-> outValid && outFcsValid)
    else $error("end beat without fcs valid");
  a_fcs_on_eop: assert property ((outFcsValid || outFcsError) |-> outEop)
    else $error("fcs flag away from end beat");
  a_err_valid: assert property (outFcsError |-> outFcsValid)
    else $error("fcs error without fcs valid");
  a_beats_contig: assert property
    (outValid && !outEop |=> outValid && !outSop)
    else $error("frame beats not contiguous");
  a_new_frame: assert property (sFrameEnd ##1 outValid |-> outSop)
    else $error("beat after end lacks start marker");
endmodule

bind ermd_rx_mac ermd_rx_mac_asserts chk (
  .mclk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .lineValid, .lineCtrl, .lineData,
  .outData, .outValid, .outSop, .outEop, .outFcsValid, .outFcsError
);

//--- test/ermd_rx_mac_tb.sv
// Purpose: Self-checking bench for the receive MAC datapath.
// Assumes: Register writes only while the line is idle.
// Notes:   Reset values and an unmapped index first, then frame table, lead faults, stats and reset.
`timescale 1ns/1ps
`include "ermd_consts.vh"

module ermd_rx_mac_tb;
  typedef struct {
    logic [31:0] flt, crc, pad, pp, dmc, tyop;
    int len; bit bad; int beats; logic err;
  } ermd_row_t;
  localparam logic [31:0] T = 32'h08000000, P = 32'h88080001;
  localparam logic [31:0] C = 32'h88080002, L = 32'h00100000;
  logic        mclk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
  logic [11:0] adr = 0;
  logic [3:0]  sel = 4'hf;
  logic [31:0] dat = 0, q;
  wire  [31:0] rdat;
  wire         ack, lv, lc, oV, oS, oE, oFv, oFe;
  wire  [7:0]  ld, oD;
  logic [7:0]  rx [0:2047];
  logic        errAt, sop0;
  int          rxCnt, eopCnt, errors, checked, acc, drop, oct;
  ermd_row_t   rows [17];

  always #2.5 mclk = ~mclk;

  ermd_rx_mac uut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .lineValid(lv),
    .lineCtrl(lc), .lineData(ld), .outData(oD), .outValid(oV),
    .outSop(oS), .outEop(oE), .outFcsValid(oFv), .outFcsError(oFe));
  ermd_line_model line (.mclk(mclk), .lineValid(lv), .lineCtrl(lc),
    .lineData(ld));

  always @(posedge mclk) if (oV === 1'b1) begin
    if (rxCnt == 0) sop0 = oS;
    rx[rxCnt] = oD;
    rxCnt++;
    if (oE === 1'b1) begin
      eopCnt++;
      errAt = oFe;
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task report_and_stop;
    if (errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chkReg(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %0t: value %h, expected %h", $time, g, e);
    end
  endtask
  task chkNum(input int g, input int e);
    checked++;
    if (g != e) begin
      errors++;
      $display("CHECK FAILED %0t: count %0d, expected %0d", $time, g, e);
    end
  endtask
  task chkBit(input logic g, input logic e);
    chkReg({31'h0, g}, {31'h0, e});
  endtask
  task wb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    int n;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {idx, 2'b00};
    dat <= d;
    n = 0;
    do begin @(posedge mclk); n++; end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin chkBit(ack, 1'b1); report_and_stop; end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task waitEop(input int n);
    int k;
    for (k = 0; k < 900 && eopCnt < n; k++) @(posedge mclk);
    if (eopCnt < n) begin chkNum(eopCnt, n); report_and_stop; end
    repeat (4) @(posedge mclk);
  endtask
  task setCfg(input ermd_row_t r);
    wb(1, `ERMD_IDX_FILTER, r.flt);
    wb(1, `ERMD_IDX_CRC, r.crc);
    wb(1, `ERMD_IDX_PAD, r.pad);
    wb(1, `ERMD_IDX_PREAMBLE, r.pp);
    wb(1, `ERMD_IDX_DMCTRL, r.dmc);
    rxCnt = 0;
    eopCnt = 0;
  endtask
  task chkRst;
    wb(0, `ERMD_IDX_FILTER, 0); chkReg(q, `ERMD_RST_FILTER);
    wb(0, `ERMD_IDX_CRC, 0); chkReg(q, `ERMD_RST_CRC);
    wb(0, `ERMD_IDX_PAD, 0); chkReg(q, `ERMD_RST_PAD);
    wb(0, `ERMD_IDX_PREAMBLE, 0); chkReg(q, `ERMD_RST_PP);
  endtask
  function logic [7:0] expByte(input int k, input logic pp);
    if (!pp) return line.frm[k];
    if (k >= 8) return line.frm[k-8];
    return k == 0 ? 8'hfb : (k == 7 ? 8'hd5 : 8'h55);
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rows[0]  = '{0, 2, 0, 0, 0, T, 64, 0, 60, 0};
    rows[1]  = '{0, 0, 0, 0, 0, T, 64, 0, 64, 0};
    rows[2]  = '{0, 2, 0, 0, 0, T, 64, 1, 60, 1};
    rows[3]  = '{0, 2, 0, 1, 0, T, 64, 0, 68, 0};
    rows[4]  = '{8, 2, 0, 0, 0, T, 60, 0, 0, 0};
    rows[5]  = '{0, 2, 0, 0, 0, T, 60, 0, 56, 0};
    rows[6]  = '{32'h20, 2, 0, 0, 0, T, 64, 1, 0, 0};
    rows[7]  = '{32'h21, 2, 0, 0, 0, T, 100, 1, 96, 1};
    rows[8]  = '{32'h110, 2, 0, 0, 0, T, 145, 0, 0, 0};
    rows[9]  = '{32'h10, 2, 0, 0, 0, T, 121, 0, 0, 0};
    rows[10] = '{2, 2, 0, 0, 0, P, 64, 0, 0, 0};
    rows[11] = '{4, 2, 0, 0, 0, C, 64, 0, 0, 0};
    rows[12] = '{4, 2, 0, 0, 0, P, 64, 0, 60, 0};
    rows[13] = '{0, 2, 0, 0, 32'h40000001, T, 64, 0, 0, 0};
    rows[14] = '{1, 2, 0, 0, 32'h40000001, T, 100, 0, 96, 0};
    rows[15] = '{0, 2, 1, 0, 0, L, 64, 0, 30, 0};
    rows[16] = '{9, 2, 0, 0, 0, T, 60, 0, 0, 0};
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    chkRst;
    wb(1, 10'h3ff, 32'hffffffff);
    wb(0, 10'h3ff, 0); chkReg(q, 0);
    wb(1, `ERMD_IDX_MAXLEN, 32'd100);
    foreach (rows[r]) begin
      setCfg(rows[r]);
      line.send(rows[r].len, rows[r].tyop, rows[r].bad, 6, 8'hd5, 12);
      waitEop(rows[r].beats > 0);
      chkNum(rxCnt, rows[r].beats);
      for (int k = 0; k < rxCnt; k++)
        chkReg({24'h0, rx[k]}, {24'h0, expByte(k, rows[r].pp[0])});
      if (rxCnt > 0) chkBit(sop0, 1'b1);
      if (rxCnt > 0) chkBit(errAt, rows[r].err);
      if (rows[r].beats > 0) begin
        acc++;
        oct += rows[r].len;
      end
      else drop++;
    end
    setCfg(rows[0]);
    line.send(64, T, 0, 5, 8'hd5, 12);
    waitEop(0);
    chkNum(rxCnt, 0);
    line.send(64, T, 0, 6, 8'hd4, 12);
    waitEop(0);
    chkNum(rxCnt, 0);
    line.send(64, T, 0, 6, 8'hd5, 1);
    line.send(64, T, 1, 6, 8'hd5, 12);
    waitEop(2);
    chkNum(rxCnt, 120);
    chkBit(errAt, 1'b1);
    wb(1, `ERMD_IDX_DAHI, 32'h5a5b);
    wb(1, `ERMD_IDX_DALO, 32'h58595e5f);
    setCfg(rows[13]);
    line.send(64, T, 0, 6, 8'hd5, 12);
    waitEop(1);
    chkNum(rxCnt, 60);
    wb(1, `ERMD_IDX_STATS, 32'hffffffff);
    wb(0, `ERMD_IDX_STATS, 0);
    chkReg(q, {drop[15:0], acc[15:0] + 16'd3});
    wb(0, `ERMD_IDX_OCTETS, 0);
    chkReg(q, oct + 192);
    wb(1, `ERMD_IDX_CRC, 0);
    wb(1, `ERMD_IDX_PAD, 1);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    chkRst;
    report_and_stop;
  end
endmodule
